// >>> fault_out_defines.svh
// Constants for the position sensor fault output logic
`ifndef FAULT_OUT_DEFINES_SVH
`define FAULT_OUT_DEFINES_SVH

// Settle time after power-up, in microseconds
`define POWER_UP_SETTLE_TIME_US 20000
// Clock rate in MHz
`define CORE_CLK_MHZ 10
// Settle time in cycles, the exact product of time and clock rate (no rounding)
`define POWER_UP_SETTLE_CYCLES (`POWER_UP_SETTLE_TIME_US * `CORE_CLK_MHZ)
// Counter width for the settle count
`define SETTLE_CNT_W 18

`endif

// >>> fault_out_pkg.sv
// Types for the position sensor fault output logic
package fault_out_pkg;

    // Output hold state machine, one-hot
    typedef enum logic [2:0] {
        HOLD_WAIT_REL = 3'h1,
        HOLD_WAIT_CMP = 3'h2,
        RUNNING = 3'h4
    } hold_state_t;

endpackage : fault_out_pkg

// >>> position_sensor_fault_outputs.sv
// Field flag and incremental output diagnostic logic
`timescale 1ns/1ps
`include "fault_out_defines.svh"

module position_sensor_fault_outputs #(
    parameter int SETTLE_CYCLES = `POWER_UP_SETTLE_CYCLES
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Enable input from the receiver, active low
    input wire logic output_hold_release_n,
    // Measurement side status
    input wire logic field_too_weak,
    input wire logic field_too_strong,
    input wire logic field_rising,
    input wire logic field_falling,
    input wire logic offset_comp_done,
    input wire logic supply_fail,
    // Raw incremental signals from the interpolator
    input wire logic quad_a_raw,
    input wire logic quad_b_raw,
    input wire logic index_raw,
    // Incremental outputs
    output logic quad_a,
    output logic quad_b,
    output logic index_out,
    // Open-drain field flags, enable high while pulling low
    output logic field_rising_flag_n_o,
    output logic field_rising_flag_n_oe,
    output logic field_falling_flag_n_o,
    output logic field_falling_flag_n_oe,
    // Status
    output logic outputs_held
);

    initial begin
        if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << `SETTLE_CNT_W)) begin
            $error("SETTLE_CYCLES out of range");
        end
    end

    // Output is high when forced on or when the level itself is high
    function automatic logic or_force(input logic force_on, input logic level);
        return force_on | level;
    endfunction : or_force

    ////////////////////////////////////////////////////////////////////////
    // Hold state machine

    fault_out_pkg::hold_state_t state_r;
    fault_out_pkg::hold_state_t state_nxt;
    logic [`SETTLE_CNT_W-1:0] settle_cnt_r;
    logic comp_done_r;
    logic settle_done;

    assign settle_done = (settle_cnt_r == `SETTLE_CNT_W'(SETTLE_CYCLES - 1));

    // Compensation counts as done on its flag or at the settle limit
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            settle_cnt_r <= '0;
            comp_done_r <= 1'b0;
        end else if (clk_en && !comp_done_r) begin
            settle_cnt_r <= settle_cnt_r + `SETTLE_CNT_W'(1);
            comp_done_r <= offset_comp_done | settle_done;
        end
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            fault_out_pkg::HOLD_WAIT_REL: begin
                if (!output_hold_release_n) begin
                    state_nxt = fault_out_pkg::HOLD_WAIT_CMP;
                end
            end
            fault_out_pkg::HOLD_WAIT_CMP: begin
                if (comp_done_r) begin
                    state_nxt = fault_out_pkg::RUNNING;
                end
            end
            fault_out_pkg::RUNNING: begin
                state_nxt = fault_out_pkg::RUNNING;
            end
            default: begin
                state_nxt = fault_out_pkg::HOLD_WAIT_REL;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= fault_out_pkg::HOLD_WAIT_REL;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Incremental outputs

    logic hold_all;
    logic index_gated;
    logic [2:0] inc_raw;
    logic [2:0] inc_out;

    assign hold_all = (state_r != fault_out_pkg::RUNNING);
    assign index_gated = index_raw & ~quad_a_raw & ~quad_b_raw;

    // Bit 2 is A, bit 1 is B, bit 0 is index
    assign inc_raw = {quad_a_raw, quad_b_raw, index_gated};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_inc
            logic out_r;

            // Forced high while held, so the receiver sees the fault state
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    out_r <= 1'b1;
                end else if (clk_en) begin
                    out_r <= or_force(hold_all, inc_raw[gi]);
                end
            end

            assign inc_out[gi] = out_r;
        end
    endgenerate

    assign quad_a = inc_out[2];
    assign quad_b = inc_out[1];
    assign index_out = inc_out[0];
    assign outputs_held = hold_all;

    ////////////////////////////////////////////////////////////////////////
    // Field flags

    logic out_of_range;
    logic [1:0] drift;
    logic [1:0] pull;

    assign out_of_range = field_too_weak | field_too_strong | supply_fail;

    // Bit 1 is the rising flag, bit 0 the falling flag
    assign drift = {field_rising, field_falling};

    generate
        for (gi = 0; gi < 2; gi++) begin : g_flag
            logic pull_r;

            // Pulled low from reset until a measurement reports in range, no supply fail and no drift in this flag's direction
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    pull_r <= 1'b1;
                end else if (clk_en) begin
                    pull_r <= or_force(out_of_range, drift[gi]);
                end
            end

            assign pull[gi] = pull_r;
        end
    endgenerate

    assign field_rising_flag_n_o = 1'b0;
    assign field_falling_flag_n_o = 1'b0;
    assign field_rising_flag_n_oe = pull[1];
    assign field_falling_flag_n_oe = pull[0];

endmodule : position_sensor_fault_outputs

// >>> psfo_props.sv
// Checker for the fault output block
`timescale 1ns/1ps
module psfo_props (
    input wire logic core_clk, rst_n, clk_en, output_hold_release_n,
    input wire logic field_too_weak, field_too_strong, field_rising,
    input wire logic field_falling, offset_comp_done, supply_fail, quad_a,
    input wire logic quad_b, index_out, outputs_held,
    input wire logic field_rising_flag_n_oe, field_falling_flag_n_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire r = field_rising_flag_n_oe, f = field_falling_flag_n_oe;
    wire h = outputs_held, bad = field_too_weak || field_too_strong;
    wire ok = clk_en && !h && !supply_fail && !bad;
    wire go = clk_en && !output_hold_release_n && offset_comp_done;
    sequence rel_s; go [*4]; endsequence
    held_high_a: assert property (h |-> quad_a && quad_b && index_out)
        else $error("hold");
    index_gate_a: assert property (index_out && !$past(h)
        |-> !quad_a && !quad_b) else $error("index");
    hold_exit_a: assert property (rel_s |=> !h) else $error("exit");
    no_reenter_a: assert property (!h |=> !h) else $error("rehold");
    range_flag_a: assert property (clk_en && bad |=> r && f)
        else $error("range");
    supply_flag_a: assert property (clk_en && supply_fail |=> r && f)
        else $error("supply");
    rise_flag_a: assert property (ok && field_rising && !field_falling
        |=> r && !f) else $error("rise");
    quiet_flag_a: assert property (ok && !field_rising && !field_falling
        |=> !r && !f) else $error("quiet");
endmodule : psfo_props
bind position_sensor_fault_outputs psfo_props i_psfo_props (.*);

// >>> rx_model.sv
// Receiving controller model
`timescale 1ns/1ps
module rx_model (input wire logic quad_a, quad_b, index_out,
    output logic fail);
    assign fail = quad_a && quad_b && index_out;
endmodule : rx_model

// >>> tb_position_sensor_fault_outputs.sv
// Testbench for the fault output block
`timescale 1ns/1ps
module tb_position_sensor_fault_outputs;
    logic core_clk = 0, rst_n = 0, clk_en = 1, output_hold_release_n = 1;
    logic offset_comp_done = 0, quad_a_raw = 0, quad_b_raw = 0, index_raw = 1;
    logic field_too_weak = 0, field_too_strong = 0, field_rising = 0;
    logic field_falling = 0, supply_fail = 0, fail, quad_a, quad_b, index_out;
    logic outputs_held, field_rising_flag_n_o, field_rising_flag_n_oe;
    logic field_falling_flag_n_o, field_falling_flag_n_oe;
    int miscompares = 0, checked = 0;
    always #50 core_clk = ~core_clk;
    position_sensor_fault_outputs #(.SETTLE_CYCLES(10))
        i_position_sensor_fault_outputs (.*);
    rx_model i_rx_model (.*);
    task chk(string n, logic e, logic s);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s exp %b got %b", n, e, s);
        end
    endtask : chk
    task boot(logic r);
        @(posedge core_clk);
        output_hold_release_n <= r;
        rst_n <= 0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1;
    endtask : boot
    task t_early;
        boot(0);
        repeat (5) @(negedge core_clk);
        chk("all high", 1, fail);
        repeat (20) @(negedge core_clk);
        chk("held", 0, outputs_held);
        $display("test early done");
    endtask : t_early
    task t_hold;
        boot(1);
        repeat (30) @(negedge core_clk);
        chk("all high", 1, fail);
        @(posedge core_clk);
        output_hold_release_n <= 0;
        offset_comp_done <= 1;
        repeat (6) @(negedge core_clk);
        chk("a follows raw", 0, quad_a);
        chk("released", 0, outputs_held);
        $display("test hold done");
    endtask : t_hold
    task t_flags;
        logic [4:0] cs [6] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h00};
        logic [1:0] ex [6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h3};
        for (int k = 0; k < 6; k++) begin
            @(posedge core_clk);
            {field_too_weak, field_too_strong, field_rising, field_falling,
                supply_fail} <= cs[k];
            {quad_a_raw, quad_b_raw, index_raw} <= 3'h7;
            repeat (2) @(negedge core_clk);
            chk("rise pin", ex[k][1], !field_rising_flag_n_oe);
            chk("fall pin", ex[k][0], !field_falling_flag_n_oe);
        end
        chk("index", 0, index_out);
        @(posedge core_clk);
        clk_en <= 0;
        field_too_weak <= 1;
        repeat (2) @(negedge core_clk);
        chk("frozen pin", 1, !field_rising_flag_n_oe);
        @(posedge core_clk);
        clk_en <= 1;
        repeat (2) @(negedge core_clk);
        chk("weak pin", 0, !field_rising_flag_n_oe);
        $display("test flags done");
    endtask : t_flags
    task results;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results
    initial begin
        t_early;
        t_hold;
        t_flags;
        results;
    end
    initial begin
        repeat (400) @(posedge core_clk);
        miscompares++;
        results;
    end
endmodule : tb_position_sensor_fault_outputs
